// ===== bulk_in_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bulk_in_checker (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic empty_token_response_select, // ZLP select
  input wire logic udc_ack, // Ack
  input wire logic udc_nak, // Nak
  input wire logic udc_token, // Token
  input wire logic fct_rewind, // Rewind
  input wire logic fct_pkt_ack, // Ack out
  input wire logic [bulk_in_pkg::LEN_W-1:0] pkt_len, // Length
  input wire logic [bulk_in_pkg::CNT_W-1:0] pkt_count, // Depth
  input wire logic cq_full, // Full
  input wire logic tok_zlp, // ZLP
  input wire logic tok_nak // NAK
);
  import bulk_in_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rewind_next: assert property (udc_nak |=> fct_rewind)
    else $error("rewind missing");
  a_rewind_cause: assert property (fct_rewind |-> $past(udc_nak))
    else $error("rewind without nak");
  a_ack_cause: assert property (fct_pkt_ack |-> $past(udc_ack))
    else $error("ack pulse without ack");
  a_zlp_token: assert property (udc_token && pkt_count == 0 &&
    empty_token_response_select |=> tok_zlp && !tok_nak) else $error("no zlp answer");
  a_nak_token: assert property (udc_token && pkt_count == 0 &&
    !empty_token_response_select |=> tok_nak && !tok_zlp) else $error("no nak answer");
  a_answer_cause: assert property (tok_zlp || tok_nak |-> $past(udc_token))
    else $error("answer without token");
  a_full_flag: assert property (cq_full == (pkt_count == CQ_FULL_CNT))
    else $error("full flag wrong");
  a_depth_cap: assert property (pkt_count <= CQ_FULL_CNT)
    else $error("depth above limit");
  a_empty_len: assert property (pkt_count == 0 |-> pkt_len == 0)
    else $error("length with empty queue");
endmodule : bulk_in_checker
bind usb_bulk_in_frame_packer bulk_in_checker chk (.core_clk, .rst,
  .empty_token_response_select, .udc_ack, .udc_nak, .udc_token, .fct_rewind,
  .fct_pkt_ack, .pkt_len, .pkt_count, .cq_full, .tok_zlp, .tok_nak);
`default_nettype wire

// ===== bulk_in_pkg.sv
package bulk_in_pkg;
  localparam int DATA_W = 32;
  localparam int MEM_DEPTH = 2048;
  localparam int MEM_AW = 11;
  localparam int PTR_W = 12;
  localparam int CQ_DEPTH = 32;
  localparam int CQ_AW = 5;
  localparam int CNT_W = 6;
  localparam int LEN_W = 11;
  localparam int FLEN_W = 14;
  localparam int FLEN_LSB = 0;
  localparam int IN_FIFO_DEPTH = 4;
  localparam logic [3:0] CMD_WORDS = 4'h3;
  localparam logic [PTR_W-1:0] MEM_WORDS = 12'h800;
  localparam logic [CNT_W-1:0] CQ_FULL_CNT = 6'h20;
  localparam logic [LEN_W-1:0] MPS_SS = 11'h400;
  localparam logic [LEN_W-1:0] MPS_HS = 11'h200;
  localparam logic [LEN_W-1:0] MPS_FS = 11'h040;
  localparam logic [LEN_W-1:0] WORD_BYTES = 11'h004;
  typedef enum logic [1:0] {SPEED_FS, SPEED_HS, SPEED_SS} speed_t;
  typedef enum logic [1:0] {PK_CMD_A, PK_BODY, PK_ZLP} pack_state_t;
endpackage : bulk_in_pkg

// ===== frame_source.sv
`timescale 1ns/100ps
`default_nettype none
module frame_source (
  input wire logic core_clk, // Clock
  input wire logic fct_ready, // Accepted
  output logic [31:0] fct_data, // Word
  output logic fct_valid, // Valid
  output logic fct_frame_avail // More frames
);
  initial begin
    fct_data = 32'h0;
    fct_valid = 1'b0;
    fct_frame_avail = 1'b0;
  end
  task automatic send(input logic [13:0] len, input logic more);
    logic [31:0] w;
    for (int i = 0; i < 3 + (len + 3) / 4; i++) begin
      w = i == 0 ? {18'h0, len} : {16'hA5C3, 16'(i)};
      fct_data <= w;
      fct_valid <= 1'b1;
      fct_frame_avail <= more;
      do @(posedge core_clk); while (fct_ready !== 1'b1);
    end
    fct_valid <= 1'b0;
    fct_data <= ~w;
    @(posedge core_clk);
  endtask : send
endmodule : frame_source
`default_nettype wire

// ===== stream_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic [WIDTH-1:0] in_data, // Write word
  input wire logic in_valid, // Write request
  output logic in_ready, // Space free
  output logic [WIDTH-1:0] out_data, // Head word
  output logic out_valid, // Head valid
  input wire logic out_ready // Head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      in_ready <= cnt_nxt < (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
endmodule : stream_fifo
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bulk_in_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, multi_frame_packing = 1'b0;
  logic empty_token_response_select = 1'b0;
  speed_t speed = SPEED_FS;
  logic udc_rd_en = 1'b0, udc_ack = 1'b0, udc_nak = 1'b0, udc_token = 1'b0;
  logic [DATA_W-1:0] fct_data, udc_rd_data;
  logic fct_valid, fct_ready, fct_frame_avail, fct_rewind, fct_pkt_ack;
  logic cq_full, tok_zlp, tok_nak;
  logic [LEN_W-1:0] pkt_len;
  logic [CNT_W-1:0] pkt_count;
  int err_count = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  usb_bulk_in_frame_packer uut (.core_clk, .rst, .multi_frame_packing,
    .empty_token_response_select, .speed, .fct_data, .fct_valid, .fct_ready,
    .fct_frame_avail, .fct_rewind, .fct_pkt_ack, .pkt_len, .pkt_count, .cq_full,
    .udc_rd_en, .udc_rd_data, .udc_ack, .udc_nak, .udc_token, .tok_zlp, .tok_nak);
  frame_source src (.core_clk, .fct_ready, .fct_data, .fct_valid, .fct_frame_avail);
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_cnt(input logic [CNT_W-1:0] n);
    for (int k = 0; k < 400 && pkt_count !== n; k++) @(posedge core_clk);
    chk("pkt_count", pkt_count, n);
  endtask : wait_cnt
  // Controller side: take each head length, then acknowledge it
  task automatic drain(input int lens[$]);
    foreach (lens[i]) begin
      chk("pkt_len", pkt_len, lens[i]);
      udc_ack <= 1'b1;
      @(posedge core_clk);
      udc_ack <= 1'b0;
      @(negedge core_clk);
      chk("fct_pkt_ack", fct_pkt_ack, 1'b1);
      repeat (2) @(posedge core_clk);
    end
    chk("pkt_count", pkt_count, 0);
  endtask : drain
  task automatic t_token;
    for (int s = 0; s < 2; s++) begin
      empty_token_response_select <= s[0];
      udc_token <= 1'b1;
      @(posedge core_clk);
      udc_token <= 1'b0;
      @(negedge core_clk);
      chk("tok_zlp", tok_zlp, s[0]);
      chk("tok_nak", tok_nak, !s[0]);
      @(posedge core_clk);
    end
    $display("token test done");
  endtask : t_token
  task automatic t_single;
    src.send(14'h5, 1'b0);
    wait_cnt(6'h1);
    chk("rd_data", udc_rd_data, 32'h5);
    udc_rd_en <= 1'b1;
    @(posedge core_clk);
    udc_rd_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rd_data", udc_rd_data, 32'hA5C30001);
    udc_nak <= 1'b1;
    @(posedge core_clk);
    udc_nak <= 1'b0;
    @(negedge core_clk);
    chk("fct_rewind", fct_rewind, 1'b1);
    repeat (2) @(posedge core_clk);
    chk("rd_data", udc_rd_data, 32'h5);
    drain('{17});
    $display("single test done");
  endtask : t_single
  task automatic t_pack;
    src.send(14'h34, 1'b0);
    wait_cnt(6'h2);
    drain('{64, 0});
    speed <= SPEED_HS;
    src.send(14'h3E8, 1'b0);
    wait_cnt(6'h2);
    drain('{512, 500});
    multi_frame_packing <= 1'b1;
    speed <= SPEED_SS;
    src.send(14'h5, 1'b1);
    src.send(14'h6, 1'b0);
    wait_cnt(6'h1);
    drain('{38});
    speed <= SPEED_FS;
    src.send(14'h1E, 1'b1);
    src.send(14'h1E, 1'b0);
    wait_cnt(6'h2);
    drain('{64, 22});
    multi_frame_packing <= 1'b0;
    src.send(14'h5, 1'b1);
    src.send(14'h6, 1'b0);
    wait_cnt(6'h2);
    drain('{17, 18});
    $display("packing test done");
  endtask : t_pack
  task automatic t_full;
    int lens[$];
    for (int i = 0; i < 33; i++) begin
      src.send(14'h1, 1'b0);
      lens.push_back(13);
    end
    repeat (20) @(posedge core_clk);
    chk("pkt_count", pkt_count, 6'h20);
    chk("cq_full", cq_full, 1'b1);
    drain(lens);
    $display("full test done");
  endtask : t_full
  // Mid-run reset must drop a half-built packet and both pointers
  task automatic t_reset;
    multi_frame_packing <= 1'b1;
    src.send(14'h5, 1'b1);
    repeat (4) @(posedge core_clk);
    chk("pkt_count", pkt_count, 0);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    multi_frame_packing <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("fct_ready", fct_ready, 1'b1);
    src.send(14'h9, 1'b0);
    wait_cnt(6'h1);
    chk("rd_data", udc_rd_data, 32'h9);
    drain('{21});
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("pkt_count", pkt_count, 0);
    chk("fct_ready", fct_ready, 1'b1);
    t_token();
    t_single();
    t_pack();
    t_full();
    t_reset();
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// ===== usb_bulk_in_frame_packer.sv
// Summary of operation
// - Packets are buffered in a 2K x 32 dual-port data memory, 8 KB.
// - Packets and frames each start on a 32-bit word boundary.
// - Multi-frame mode pads a non-final frame to a word; pad counts in length.
// - Final word's unused bytes are left out of the last packet and its length.
// - Every packet length, zero-length too, is pushed into the length queue.
// - The length queue holds at most 32 entries.
// - A full length queue stalls packing even with free data memory.
// - Queue head is the packet length; its count is the packets available.
// - One configuration bit selects multi-frame or single-frame packing.
// - Multi-frame mode packs several frames per packet, splitting long ones.
// - Single-frame mode carries one frame per packet, splitting long ones.
// - Each frame has three command words; the first gives the frame length.
// - A burst ends in a short packet, or a ZLP after an exact multiple.
// - Token with nothing queued gives a ZLP if selected, else a NAK.
// - An unacknowledged packet rewinds the frame FIFO and is resent.
// - Only an acknowledge pops the length and frees data; ZLPs free none.
`timescale 1ns/100ps
`default_nettype none
module usb_bulk_in_frame_packer (
  input wire logic core_clk, // 10 MHz clock
  input wire logic rst, // Async reset, high
  input wire logic multi_frame_packing, // 1 multi-frame, 0 single-frame
  input wire logic empty_token_response_select, // ZLP on empty token
  input wire bulk_in_pkg::speed_t speed, // Link speed
  input wire logic [bulk_in_pkg::DATA_W-1:0] fct_data, // Frame word
  input wire logic fct_valid, // Frame word valid
  output logic fct_ready, // Frame word taken
  input wire logic fct_frame_avail, // Another frame waits
  output logic fct_rewind, // Resend pulse to frame FIFO
  output logic fct_pkt_ack, // Acknowledge pulse to frame FIFO
  output logic [bulk_in_pkg::LEN_W-1:0] pkt_len, // Head packet length
  output logic [bulk_in_pkg::CNT_W-1:0] pkt_count, // Packets available
  output logic cq_full, // Length queue full
  input wire logic udc_rd_en, // Take one data word
  output logic [bulk_in_pkg::DATA_W-1:0] udc_rd_data, // Data word at read pointer
  input wire logic udc_ack, // Head packet acknowledged
  input wire logic udc_nak, // Sent packets not acknowledged
  input wire logic udc_token, // Bulk In token
  output logic tok_zlp, // Answer token with ZLP
  output logic tok_nak // Answer token with NAK/NRDY
);
  import bulk_in_pkg::*;

  logic [DATA_W-1:0] dmem [MEM_DEPTH];
  logic [LEN_W-1:0] cq_mem [CQ_DEPTH];

  logic [DATA_W-1:0] fw_data;
  logic fw_valid, fw_ready;

  stream_fifo #(.WIDTH(DATA_W), .DEPTH(IN_FIFO_DEPTH)) in_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(fct_data),
    .in_valid(fct_valid),
    .in_ready(fct_ready),
    .out_data(fw_data),
    .out_valid(fw_valid),
    .out_ready(fw_ready)
  );

  pack_state_t st_r, st_nxt;
  logic [PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt, fp_r, fp_nxt;
  logic [FLEN_W-1:0] words_left_r, words_left_nxt;
  logic [1:0] tail_r, tail_nxt;
  logic [LEN_W-1:0] pb_r, pb_nxt;
  logic [CQ_AW-1:0] cq_wp_r, cq_wp_nxt, cq_rp_r, cq_rp_nxt;
  logic [CNT_W-1:0] cq_cnt_r, cq_cnt_nxt;
  logic [LEN_W-1:0] mps, word_bytes, sum, push_len, head_len;
  logic [FLEN_W-1:0] flen;
  logic take, last_word, close, zlp_after, push, pop, mem_full, cq_full_now;
  logic [LEN_W-1:0] pkt_len_nxt;
  logic fct_rewind_nxt, fct_pkt_ack_nxt, tok_zlp_nxt, tok_nak_nxt, cq_full_nxt;

  always_comb begin
    unique case (speed)
      SPEED_SS: mps = MPS_SS;
      SPEED_HS: mps = MPS_HS;
      default: mps = MPS_FS;
    endcase
  end

  // Packing path
  always_comb begin
    st_nxt = st_r;
    wp_nxt = wp_r;
    words_left_nxt = words_left_r;
    tail_nxt = tail_r;
    pb_nxt = pb_r;
    push = 1'b0;
    push_len = pb_r;
    close = 1'b0;
    zlp_after = 1'b0;
    word_bytes = WORD_BYTES;
    mem_full = (wp_r - fp_r) == MEM_WORDS;
    cq_full_now = cq_cnt_r == CQ_FULL_CNT;
    flen = fw_data[FLEN_LSB +: FLEN_W];
    // The count reaches one while the frame's final word is at the head
    last_word = (st_r == PK_CMD_A) ? 1'b0 : (words_left_r == FLEN_W'(1));
    take = fw_valid && !mem_full && !cq_full_now && (st_r != PK_ZLP);
    if (st_r == PK_BODY && last_word && tail_r != 2'h0 &&
        !(multi_frame_packing && fct_frame_avail)) begin
      word_bytes = {{(LEN_W-2){1'b0}}, tail_r};
    end
    sum = pb_r + word_bytes;
    if (st_r == PK_ZLP) begin
      if (!cq_full_now) begin
        push = 1'b1;
        push_len = '0;
        st_nxt = PK_CMD_A;
      end
    end else if (take) begin
      wp_nxt = wp_r + 1'b1;
      pb_nxt = sum;
      if (st_r == PK_CMD_A) begin
        words_left_nxt = {{(FLEN_W-4){1'b0}}, CMD_WORDS} - 1'b1 + ((flen + 2'h3) >> 2);
        tail_nxt = flen[1:0];
        st_nxt = PK_BODY;
      end else begin
        words_left_nxt = words_left_r - 1'b1;
      end
      if (st_r == PK_BODY && last_word) begin
        st_nxt = PK_CMD_A;
        close = !multi_frame_packing || !fct_frame_avail;
        zlp_after = close && (sum == mps);
      end
      if (close || sum == mps) begin
        push = 1'b1;
        push_len = sum;
        pb_nxt = '0;
      end
      if (zlp_after) begin
        st_nxt = PK_ZLP;
      end
    end
  end

  assign fw_ready = take;

  // Length queue and release on acknowledge
  always_comb begin
    pop = udc_ack && cq_cnt_r != '0;
    head_len = cq_mem[cq_rp_r];
    cq_wp_nxt = push ? cq_wp_r + 1'b1 : cq_wp_r;
    cq_rp_nxt = pop ? cq_rp_r + 1'b1 : cq_rp_r;
    cq_cnt_nxt = cq_cnt_r + {{(CNT_W-1){1'b0}}, push} - {{(CNT_W-1){1'b0}}, pop};
    fp_nxt = fp_r;
    if (pop) begin
      fp_nxt = fp_r + PTR_W'((head_len + 2'h3) >> 2);
    end
    rp_nxt = rp_r;
    if (udc_nak) begin
      rp_nxt = fp_nxt;
    end else if (udc_rd_en && rp_r != wp_r) begin
      rp_nxt = rp_r + 1'b1;
    end
    if (cq_cnt_nxt == '0) begin
      pkt_len_nxt = '0;
    end else if (cq_cnt_r == '0 || (pop && cq_cnt_r == 6'h01)) begin
      pkt_len_nxt = push_len;
    end else begin
      pkt_len_nxt = cq_mem[cq_rp_nxt];
    end
    fct_rewind_nxt = udc_nak;
    fct_pkt_ack_nxt = pop;
    tok_zlp_nxt = udc_token && cq_cnt_r == '0 && empty_token_response_select;
    tok_nak_nxt = udc_token && cq_cnt_r == '0 && !empty_token_response_select;
    cq_full_nxt = cq_cnt_nxt == CQ_FULL_CNT;
  end

  // Packing group
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= PK_CMD_A;
      wp_r <= '0;
      words_left_r <= '0;
      tail_r <= 2'h0;
      pb_r <= '0;
    end else begin
      st_r <= st_nxt;
      wp_r <= wp_nxt;
      words_left_r <= words_left_nxt;
      tail_r <= tail_nxt;
      pb_r <= pb_nxt;
    end
  end

  // Length queue, read side and answers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rp_r <= '0;
      fp_r <= '0;
      cq_wp_r <= '0;
      cq_rp_r <= '0;
      cq_cnt_r <= '0;
      pkt_len <= '0;
      pkt_count <= '0;
      cq_full <= 1'b0;
      fct_rewind <= 1'b0;
      fct_pkt_ack <= 1'b0;
      tok_zlp <= 1'b0;
      tok_nak <= 1'b0;
    end else begin
      rp_r <= rp_nxt;
      fp_r <= fp_nxt;
      cq_wp_r <= cq_wp_nxt;
      cq_rp_r <= cq_rp_nxt;
      cq_cnt_r <= cq_cnt_nxt;
      pkt_len <= pkt_len_nxt;
      pkt_count <= cq_cnt_nxt;
      cq_full <= cq_full_nxt;
      fct_rewind <= fct_rewind_nxt;
      fct_pkt_ack <= fct_pkt_ack_nxt;
      tok_zlp <= tok_zlp_nxt;
      tok_nak <= tok_nak_nxt;
    end
  end

  // Storage arrays carry no reset; pointers define their contents
  always_ff @(posedge core_clk) begin
    if (take) begin
      dmem[wp_r[MEM_AW-1:0]] <= fw_data;
    end
    if (push) begin
      cq_mem[cq_wp_r] <= push_len;
    end
    udc_rd_data <= dmem[rp_nxt[MEM_AW-1:0]];
  end
endmodule : usb_bulk_in_frame_packer
`default_nettype wire
